// [hw/sasc_params.svh]
`ifndef SASC_PARAMS_SVH
`define SASC_PARAMS_SVH
// Contract
// - lin break flag sets on detected break while enabled; write one clears
// - rx edge flag sets on falling edge, rising when rx inverted; write one clears
// - rx inversion flips the receive input for every frame element
// - in standby, wake idle select decides whether waking idle sets idle flag
// - tx break lasts 10 or 13 bit times, one more in nine-bit mode
// - long break select changes only tx break, never framing error detection
// - rx break threshold 10 bits, or 11 with lin detect; one more in nine-bit
// - lin detect enabled blocks framing error and rx full flags from setting
// - receiver active sets on valid start bit, clears on idle line, read only
// - data write moves nine-bit value with stored tx ninth bit to shifter
// - single-wire mode: direction bit makes tx pin input at 0, output at 1
// - tx inversion flips the transmit output for every frame element
// - overrun flag and its enable raise an interrupt request
// - noise flag and its enable raise an interrupt request
// - framing error flag and its enable raise an interrupt request
// - parity error flag and its enable raise an interrupt request
// - framing error sets with rx full when stop bit samples zero
// - idle sets after one character time high: 10 or 11 bit times
`define ADDR_AUX 8'h00
`define ADDR_EXT 8'h04
`define AUX_RST 8'h00
`define EXT_RST 8'h00
`define B_LIN_BRK_FLAG 7
`define B_RX_EDGE_FLAG 6
`define B_RX_INVERT 4
`define B_WAKE_IDLE_SEL 3
`define B_LONG_BRK_SEL 2
`define B_LIN_DET_EN 1
`define B_RX_ACTIVE 0
`define B_RX_NINTH 7
`define B_TX_NINTH 6
`define B_SW_DIR 5
`define B_TX_INVERT 4
`define B_OVR_IE 3
`define B_NOISE_IE 2
`define B_FRM_IE 1
`define B_PAR_IE 0
`define TX_BRK_NORM 4'd10
`define TX_BRK_LONG 4'd13
`define RX_THR_NORM 4'd10
`define RX_THR_LIN 4'd11
`define IDLE_CHAR 4'd10
`define RESP_OK 2'b00
`define RESP_SLV 2'b10
`endif

// [hw/sasc_pkg.sv]
package sasc_pkg;
  // write channel progress of the register slave
  typedef enum logic [0:0] {WR_COLLECT, WR_RESP} wr_st_t;
  typedef logic [7:0] reg8_t;
endpackage

// [hw/serial_aux_status_control.sv]
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`include "sasc_params.svh"
module serial_aux_status_control
  import sasc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              nine_bit_mode,
  input  wire logic              bit_tick,
  input  wire logic              rx_pin,
  input  wire logic              rx_start_det,
  input  wire logic              rx_idle_det,
  input  wire logic              rx_char_done,
  input  wire logic              rx_stop_zero,
  input  wire logic              rx_ninth_in,
  input  wire logic              idle_detect,
  input  wire logic              receiver_standby,
  input  wire logic              loop_mode_sel,
  input  wire logic              receiver_source_sel,
  input  wire logic              tx_line,
  input  wire logic              data_wr,
  input  wire logic [7:0]        data_wr_byte,
  input  wire logic              overrun_flag,
  input  wire logic              noise_flag,
  input  wire logic              framing_error_flag,
  input  wire logic              parity_error_flag,
  output logic                   rx_data,
  output logic                   tx_pin_o,
  output logic                   tx_pin_oe,
  output logic                   framing_set,
  output logic                   rx_full_set,
  output logic                   idle_set,
  output logic [3:0]             tx_break_bits,
  output logic [3:0]             rx_break_bits,
  output logic [3:0]             idle_char_bits,
  output logic                   tx_load,
  output logic [8:0]             tx_word,
  output logic                   receiver_active_flag,
  output logic                   err_irq
);

  // transmitted break length in bit times
  function automatic logic [3:0] tx_brk_len(input logic long_sel, input logic m9);
    tx_brk_len = (long_sel ? `TX_BRK_LONG : `TX_BRK_NORM) + {3'b000, m9};
  endfunction

  // receive break threshold in bit times
  function automatic logic [3:0] rx_brk_thr(input logic lin_en, input logic m9);
    rx_brk_thr = (lin_en ? `RX_THR_LIN : `RX_THR_NORM) + {3'b000, m9};
  endfunction

  reg8_t       aux_q, aux_d;
  reg8_t       ext_q, ext_d;
  wr_st_t      wst_q, wst_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [7:0]  wd_q, wd_d;
  logic        wb0_q, wb0_d;
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        rx_q, rx_d, rx_prev_q, rx_prev_d;
  logic [3:0]  low_cnt_q, low_cnt_d;
  logic        frm_set_d, full_set_d, idle_set_d, txo_d, txoe_d;
  logic [3:0]  txbb_d, rxbb_d, icb_d;
  logic        txl_d, act_d, irq_d;
  logic [8:0]  txw_d;
  logic        wr_fire, clr_lbk, clr_edge, lbk_hit, edge_hit;

  // register slave: write channel collects address and data in either order
  always_comb begin
    awready_d = awready;
    wready_d  = wready;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    wb0_d     = wb0_q;
    wst_d     = wst_q;
    wr_fire   = 1'b0;
    case (wst_q)
      WR_COLLECT: begin
        if (awvalid && awready) begin
          aw_got_d  = 1'b1;
          wa_d      = awaddr;
          awready_d = 1'b0;
        end
        if (wvalid && wready) begin
          w_got_d  = 1'b1;
          wd_d     = wdata[7:0];
          wb0_d    = wstrb[0];
          wready_d = 1'b0;
        end
        if (aw_got_q && w_got_q) begin
          wr_fire  = 1'b1;
          bvalid_d = 1'b1;
          bresp_d  = (wa_q == `ADDR_AUX || wa_q == `ADDR_EXT) ? `RESP_OK : `RESP_SLV;
          wst_d    = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          bvalid_d  = 1'b0;
          aw_got_d  = 1'b0;
          w_got_d   = 1'b0;
          awready_d = 1'b1;
          wready_d  = 1'b1;
          wst_d     = WR_COLLECT;
        end
      end
      default: wst_d = WR_COLLECT;
    endcase
  end

  // register slave: read channel answers one cycle after the address
  always_comb begin
    arready_d = arready;
    rvalid_d  = rvalid;
    rdata_d   = rdata;
    rresp_d   = rresp;
    if (arvalid && arready) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = `RESP_OK;
      if (araddr == `ADDR_AUX) rdata_d = {24'h000000, aux_q};
      else if (araddr == `ADDR_EXT) rdata_d = {24'h000000, ext_q};
      else begin
        rdata_d = 32'h00000000;
        rresp_d = `RESP_SLV;
      end
    end else if (rvalid && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q    <= WR_COLLECT;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      wa_q     <= '0;
      wd_q     <= 8'h00;
      wb0_q    <= 1'b0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OK;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= `RESP_OK;
    end else begin
      wst_q    <= wst_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      wa_q     <= wa_d;
      wd_q     <= wd_d;
      wb0_q    <= wb0_d;
      awready  <= awready_d;
      wready   <= wready_d;
      bvalid   <= bvalid_d;
      bresp    <= bresp_d;
      arready  <= arready_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
      rresp    <= rresp_d;
    end
  end

  // status, control and line logic
  always_comb begin
    aux_d = aux_q;
    ext_d = ext_q;
    rx_d = rx_pin ^ aux_q[`B_RX_INVERT];
    rx_prev_d = rx_q;
    edge_hit = rx_prev_q && !rx_q;
    low_cnt_d = low_cnt_q;
    if (rx_q) low_cnt_d = 4'd0;
    else if (bit_tick && low_cnt_q != 4'hf) low_cnt_d = low_cnt_q + 4'd1;
    lbk_hit = aux_q[`B_LIN_DET_EN] && bit_tick && !rx_q &&
              (low_cnt_q + 4'd1 == rx_brk_thr(1'b1, nine_bit_mode));
    clr_lbk  = wr_fire && wb0_q && wa_q == `ADDR_AUX && wd_q[`B_LIN_BRK_FLAG];
    clr_edge = wr_fire && wb0_q && wa_q == `ADDR_AUX && wd_q[`B_RX_EDGE_FLAG];
    if (wr_fire && wb0_q && wa_q == `ADDR_AUX) begin
      aux_d[`B_RX_INVERT:`B_LIN_DET_EN] = wd_q[`B_RX_INVERT:`B_LIN_DET_EN];
    end
    if (wr_fire && wb0_q && wa_q == `ADDR_EXT) begin
      ext_d[`B_TX_NINTH:0] = wd_q[`B_TX_NINTH:0];
    end
    // set wins over a write-one clear in the same cycle
    aux_d[`B_LIN_BRK_FLAG] = lbk_hit || (aux_q[`B_LIN_BRK_FLAG] && !clr_lbk);
    aux_d[`B_RX_EDGE_FLAG] = edge_hit || (aux_q[`B_RX_EDGE_FLAG] && !clr_edge);
    aux_d[5] = 1'b0;
    if (rx_start_det) aux_d[`B_RX_ACTIVE] = 1'b1;
    else if (rx_idle_det) aux_d[`B_RX_ACTIVE] = 1'b0;
    full_set_d = rx_char_done && !aux_q[`B_LIN_DET_EN];
    frm_set_d = full_set_d && rx_stop_zero;
    if (full_set_d) ext_d[`B_RX_NINTH] = rx_ninth_in;
    idle_set_d = idle_detect && (!receiver_standby || aux_q[`B_WAKE_IDLE_SEL]);
    icb_d = `IDLE_CHAR + {3'b000, nine_bit_mode};
    txbb_d = tx_brk_len(aux_q[`B_LONG_BRK_SEL], nine_bit_mode);
    rxbb_d = rx_brk_thr(aux_q[`B_LIN_DET_EN], nine_bit_mode);
    txl_d = data_wr;
    txw_d = data_wr ? {ext_q[`B_TX_NINTH], data_wr_byte} : tx_word;
    txo_d = tx_line ^ ext_q[`B_TX_INVERT];
    txoe_d = !(loop_mode_sel && receiver_source_sel) || ext_q[`B_SW_DIR];
    irq_d = (overrun_flag && ext_q[`B_OVR_IE]) ||
            (noise_flag && ext_q[`B_NOISE_IE]) ||
            (framing_error_flag && ext_q[`B_FRM_IE]) ||
            (parity_error_flag && ext_q[`B_PAR_IE]);
    act_d = aux_d[`B_RX_ACTIVE];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_q <= `AUX_RST;
      ext_q <= `EXT_RST;
      rx_q <= 1'b1;
      rx_prev_q <= 1'b1;
      low_cnt_q <= 4'd0;
      rx_data <= 1'b1;
      tx_pin_o <= 1'b1;
      tx_pin_oe <= 1'b1;
      framing_set <= 1'b0;
      rx_full_set <= 1'b0;
      idle_set <= 1'b0;
      tx_break_bits <= `TX_BRK_NORM;
      rx_break_bits <= `RX_THR_NORM;
      idle_char_bits <= `IDLE_CHAR;
      tx_load <= 1'b0;
      tx_word <= 9'h000;
      receiver_active_flag <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      aux_q <= aux_d;
      ext_q <= ext_d;
      rx_q <= rx_d;
      rx_prev_q <= rx_prev_d;
      low_cnt_q <= low_cnt_d;
      rx_data <= rx_d;
      tx_pin_o <= txo_d;
      tx_pin_oe <= txoe_d;
      framing_set <= frm_set_d;
      rx_full_set <= full_set_d;
      idle_set <= idle_set_d;
      tx_break_bits <= txbb_d;
      rx_break_bits <= rxbb_d;
      idle_char_bits <= icb_d;
      tx_load <= txl_d;
      tx_word <= txw_d;
      receiver_active_flag <= act_d;
      err_irq <= irq_d;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_w1c_lbk;
    clr_lbk && !lbk_hit;
  endsequence

  AST_LBK_SET: assert property (lbk_hit |=> aux_q[7]) else $error("lin break flag not set");
  AST_LBK_CLR: assert property (s_w1c_lbk |=> !aux_q[7]) else $error("lin break flag not cleared");
  AST_EDGE: assert property ($fell(rx_q) |=> aux_q[6]) else $error("edge flag missed");
  AST_RX_INVERT: assert property (##1 rx_data == ($past(rx_pin) ^ $past(aux_q[4])))
    else $error("rx inversion wrong");
  AST_IDLE: assert property (idle_detect && receiver_standby && !aux_q[3] |=> !idle_set)
    else $error("idle set in standby");
  AST_TXBRK: assert property (##1 tx_break_bits == 4'd10 + 4'd3 * {3'b000, $past(aux_q[2])}
    + {3'b000, $past(nine_bit_mode)}) else $error("tx break length wrong");
  AST_FRM_IND: assert property (rx_char_done && rx_stop_zero && !aux_q[1] |=> framing_set)
    else $error("framing error lost");
  AST_RXTHR: assert property (##1 rx_break_bits == 4'd10 + {3'b000, $past(aux_q[1])}
    + {3'b000, $past(nine_bit_mode)}) else $error("rx threshold wrong");
  AST_LIN_BLK: assert property (aux_q[1] |=> !framing_set && !rx_full_set)
    else $error("flags set under lin detect");
  AST_RX_ACTIVE: assert property (rx_start_det |=> receiver_active_flag)
    else $error("active flag not set");
  AST_TX_WORD: assert property (data_wr |=> tx_load && tx_word == {$past(ext_q[6]), $past(data_wr_byte)})
    else $error("tx word wrong");
  AST_DIR: assert property (loop_mode_sel && receiver_source_sel |=> tx_pin_oe == $past(ext_q[5]))
    else $error("single wire direction wrong");
  AST_TX_INVERT: assert property (##1 tx_pin_o == ($past(tx_line) ^ $past(ext_q[4])))
    else $error("tx inversion wrong");
  AST_IRQ: assert property (overrun_flag && ext_q[3] || noise_flag && ext_q[2] |=> err_irq)
    else $error("error irq missing");
  AST_IRQ_OFF: assert property (ext_q[3:0] == 4'h0 |=> !err_irq)
    else $error("irq while disabled");
  AST_IRQ_FP: assert property (framing_error_flag && ext_q[1] || parity_error_flag && ext_q[0] |=> err_irq)
    else $error("framing or parity irq missing");

endmodule

// [verif/remote_node_model.sv]
module remote_node_model (
  input  wire logic       aclk,
  input  wire logic       brk_go,
  input  wire logic [3:0] brk_len,
  output logic            rx_line,
  output logic            bit_tick,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q  = 2'h0;
  logic [3:0] left_q = 4'h0;
  logic       tick_q = 1'b0;
  logic       busy_q = 1'b0;
  logic       line_q = 1'b1;
  assign rx_line  = line_q;
  assign bit_tick = tick_q;
  assign busy     = busy_q;
  // bit time from the bus clock, one tick every four cycles
  always @(posedge aclk) begin
    div_q  <= div_q + 2'h1;
    tick_q <= (div_q == 2'h3);
  end
  // break starts on a tick so every later tick sees the line settled low
  always @(posedge aclk) begin
    if (!busy_q && brk_go && tick_q) begin
      busy_q <= 1'b1;
      line_q <= 1'b0;
      left_q <= brk_len;
    end else if (busy_q && tick_q) begin
      left_q <= left_q - 4'h1;
      if (left_q == 4'h1) begin
        busy_q <= 1'b0;
        line_q <= 1'b1; // line pulled back up to idle
      end
    end
  end
endmodule

// [verif/serial_aux_status_control_tb_top.sv]
module serial_aux_status_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
  int          n_errors = 0;
  int          num_checks = 0;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, nine = 1'b0, stop_zero = 1'b0, ninth_in = 1'b0, standby = 1'b0, loop_sel = 1'b0;
  logic        src_sel = 1'b0, tx_line = 1'b1, brk_go = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rx_data, tx_pin_o, tx_pin_oe, framing_set, rx_full_set;
  logic        idle_set, tx_load, receiver_active_flag, err_irq, rx_line, bit_tick, busy;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, data_wr_byte = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [1:0]  bresp, rresp, wresp, rd_r;
  logic [3:0]  tx_break_bits, rx_break_bits, idle_char_bits, brk_len = 4'h0, err_in = 4'h0;
  logic [8:0]  tx_word;
  logic [4:0]  pls = 5'h0;
  // bus clock
  always #50 aclk = ~aclk;
  serial_aux_status_control uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nine_bit_mode(nine), .bit_tick, .rx_pin(rx_line),
    .rx_start_det(pls[0]), .rx_idle_det(pls[1]), .rx_char_done(pls[2]), .rx_stop_zero(stop_zero),
    .rx_ninth_in(ninth_in), .idle_detect(pls[3]), .receiver_standby(standby), .loop_mode_sel(loop_sel),
    .receiver_source_sel(src_sel), .tx_line, .data_wr(pls[4]), .data_wr_byte, .overrun_flag(err_in[3]),
    .noise_flag(err_in[2]), .framing_error_flag(err_in[1]), .parity_error_flag(err_in[0]), .rx_data, .tx_pin_o,
    .tx_pin_oe, .framing_set, .rx_full_set, .idle_set, .tx_break_bits, .rx_break_bits, .idle_char_bits, .tx_load,
    .tx_word, .receiver_active_flag, .err_irq
  );
  remote_node_model peer (.aclk, .brk_go, .brk_len, .rx_line, .bit_tick, .busy);
  // register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        wresp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
    repeat (3) @(posedge aclk); // let registered outputs follow
  endtask
  // register read
  task automatic rd(input logic [7:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    `CHK(rd_r, 2'b00)
    `CHK(rd_d[7:0] & m, e)
  endtask
  // one-cycle strobe on a receiver or data-write input, then one edge for the answer
  task automatic fire(input int k);
    @(posedge aclk);
    pls[k] <= 1'b1;
    @(posedge aclk);
    pls <= 5'h0;
    @(posedge aclk);
  endtask
  task automatic brk(input logic [3:0] n);
    @(posedge aclk);
    brk_len <= n;
    brk_go <= 1'b1;
    wait (busy);
    @(posedge aclk);
    brk_go <= 1'b0;
  endtask
  task automatic brk_end;
    wait (!busy);
    repeat (8) @(posedge aclk);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdm(8'h00, 8'hff, 8'h00);
    rdm(8'h04, 8'hff, 8'h00);
    rd(8'h08);
    `CHK({rd_r, rd_d}, {2'b10, 32'h0})
    wr(8'h0c, 8'hff);
    `CHK(wresp, 2'b10)
    wr(8'h00, 8'hff);
    `CHK(wresp, 2'b00)
    rdm(8'h00, 8'h3f, 8'h1e);
    for (int i = 0; i < 4; i++) begin
      nine <= i[0];
      wr(8'h00, i[1] ? 8'hc6 : 8'hc0);
      `CHK(tx_break_bits, 4'ha + i[0] + (i[1] ? 4'h3 : 4'h0))
      `CHK(rx_break_bits, 4'ha + i[0] + i[1])
      `CHK(idle_char_bits, 4'ha + i[0])
    end
    `CHK(rx_data, 1'b1)
    for (int i = 0; i < 4; i++) begin
      tx_line <= i[0];
      wr(8'h04, {3'h0, i[1], 4'h0});
      `CHK(tx_pin_o, i[0] ^ i[1])
    end
    wr(8'h00, 8'h10);
    `CHK(rx_data, 1'b0)
    loop_sel <= 1'b1;
    src_sel <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      wr(8'h04, {2'h0, d[0], 5'h0});
      `CHK(tx_pin_oe, d[0])
    end
    for (int i = 0; i < 4; i++) begin
      err_in <= ~(4'h1 << i);
      wr(8'h04, 8'h01 << i);
      `CHK(err_irq, 1'b0)
      err_in <= 4'h1 << i;
      repeat (3) @(posedge aclk);
      `CHK(err_irq, 1'b1)
    end
    err_in <= 4'hf;
    wr(8'h04, 8'h00);
    `CHK(err_irq, 1'b0)
    err_in <= 4'h0;
    wr(8'h04, 8'h40);
    for (int i = 0; i < 2; i++) begin
      data_wr_byte <= i[0] ? 8'h3c : 8'ha5;
      fire(4);
      `CHK({tx_load, tx_word}, {2'b11, data_wr_byte})
    end
    stop_zero <= 1'b1;
    ninth_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, i == 2 ? 8'h02 : {5'h0, i[0], 2'h0});
      fire(2);
      `CHK({framing_set, rx_full_set}, i == 2 ? 2'b00 : 2'b11)
    end
    rdm(8'h04, 8'h80, 8'h80);
    fire(0);
    @(posedge aclk);
    `CHK(receiver_active_flag, 1'b1)
    wr(8'h00, 8'h00);
    rdm(8'h00, 8'h01, 8'h01);
    fire(1);
    @(posedge aclk);
    `CHK(receiver_active_flag, 1'b0)
    for (int i = 0; i < 4; i++) begin
      standby <= i[1];
      wr(8'h00, {4'h0, i[0], 3'h0});
      fire(3);
      `CHK(idle_set, !i[1] || i[0])
    end
    nine <= 1'b0; // eight-bit frames, so the lin threshold is 11 bit times
    wr(8'h00, 8'hc2); // longer threshold chosen by software
    brk(4'ha);
    rdm(8'h00, 8'h40, 8'h40);
    brk_end;
    rdm(8'h00, 8'h80, 8'h00);
    wr(8'h00, 8'hc2);
    rdm(8'h00, 8'hc0, 8'h00);
    brk(4'hb);
    brk_end;
    wr(8'h00, 8'h02);
    rdm(8'h00, 8'h80, 8'h80);
    wr(8'h00, 8'h82);
    rdm(8'h00, 8'h80, 8'h00);
    wr(8'h00, 8'h10);
    wr(8'h00, 8'hd0);
    brk(4'h8);
    rdm(8'h00, 8'h40, 8'h00);
    brk_end;
    rdm(8'h00, 8'h40, 8'h40);
    print_verdict;
  end
endmodule
